/* File: rtl/tmra_cfg.svh */
// Address, field and reset constants for the 8-bit timer
`ifndef TMRA_CFG_SVH
`define TMRA_CFG_SVH
`define TMRA_CTRL_ADDR 8'he1
`define TMRA_PEND_ADDR 8'he2
`define TMRA_DATA_ADDR 8'he3
`define TMRA_CNT_ADDR 8'he4
`define TMRA_P0H_ADDR 8'he6
`define TMRA_CTRL_RST 8'h00
`define TMRA_B_CLKS_HI 7
`define TMRA_B_CLKS_LO 6
`define TMRA_B_MODE_HI 5
`define TMRA_B_MODE_LO 4
`define TMRA_B_CLR 3
`define TMRA_B_OVIE 2
`define TMRA_B_MCIE 1
`define TMRA_B_PCLR 0
`define TMRA_B_EDGE 0
`define TMRA_B_P0_OUT 1
`define TMRA_B_LATCH 0
`define TMRA_DIV_1024 10'h3ff
`define TMRA_DIV_256 10'h0ff
`define TMRA_DIV_64 10'h03f
`define TMRA_PEND_MC 0
`define TMRA_PEND_OV 1
`define TMRA_VEC_MC 8'hc0
`define TMRA_VEC_OV 8'hc2
`endif

/* File: rtl/tmra_pkg.sv */
// Types shared by the 8-bit timer files
package tmra_pkg;
    // Operating mode field encoding
    typedef enum logic [1:0] {
        TMRA_INTERVAL = 2'h0,
        TMRA_CAPTURE = 2'h1,
        TMRA_PWM = 2'h2,
        TMRA_PWM_ALT = 2'h3
    } tmra_mode_t;
    // Clock select field encoding
    typedef enum logic [1:0] {
        TMRA_CK_1024 = 2'h0,
        TMRA_CK_256 = 2'h1,
        TMRA_CK_64 = 2'h2,
        TMRA_CK_EXT = 2'h3
    } tmra_clksel_t;
endpackage : tmra_pkg

/* File: rtl/tmra_tick.sv */
// Timer clock tick generator: prescaler plus external clock synchroniser
`include "tmra_cfg.svh"
module tmra_tick
    import tmra_pkg::*;
#(
    parameter int DIV_W = 10
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [1:0] clk_sel,
    input wire logic ext_clk_pin,
    output logic tick
);
    logic [DIV_W-1:0] div_q, div_d; // Free running prescaler
    logic sync1_q, sync1_d; // First synchroniser stage
    logic sync2_q, sync2_d; // Second synchroniser stage
    logic sync3_q, sync3_d; // Edge history
    logic [DIV_W-1:0] mask; // Terminal count for selected ratio

    // Next values for prescaler and synchroniser
    always_comb begin
        div_d = div_q + {{(DIV_W-1){1'b0}}, 1'b1};
        sync1_d = ext_clk_pin;
        sync2_d = sync1_q;
        sync3_d = sync2_q;
        unique case (tmra_clksel_t'(clk_sel))
            TMRA_CK_1024: mask = DIV_W'(`TMRA_DIV_1024);
            TMRA_CK_256: mask = DIV_W'(`TMRA_DIV_256);
            TMRA_CK_64: mask = DIV_W'(`TMRA_DIV_64);
            TMRA_CK_EXT: mask = '0;
        endcase
        // Tick on prescaler terminal count, or synchronised rising edge
        if (tmra_clksel_t'(clk_sel) == TMRA_CK_EXT) begin
            tick = sync2_q && !sync3_q; // [RQ18]
        end else begin
            tick = ((div_q & mask) == mask); // [RQ2]
        end
    end

    // Register stage
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            div_q <= '0;
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            sync3_q <= 1'b0;
        end else begin
            div_q <= div_d;
            sync1_q <= sync1_d;
            sync2_q <= sync2_d;
            sync3_q <= sync3_d;
        end
    end
endmodule : tmra_tick

/* File: rtl/tmra_timer.sv */
// 8-bit timer/counter with interval, capture and PWM modes
`include "tmra_cfg.svh"
// How it works
// RQ1 - Three modes chosen by control mode field
// RQ2 - Clock: divide 1024, 256, 64 or external
// RQ3 - Overflow and match/capture requests, two vectors
// RQ4 - Overflow pending cleared when serviced
// RQ5 - Interval match toggles pin, interrupts, clears counter
// RQ6 - PWM counter free runs, wraps FFH to 00H
// RQ7 - PWM low when reference at most counter
// RQ8 - PWM period is 256 timer ticks
// RQ9 - Capture edge loads counter into reference
// RQ10 - Port bits select capture input or output
// RQ11 - Capture mode: overflow and capture interrupts
// RQ12 - Reset clears control register to zero
// RQ13 - Writing control bit 3 clears counter
// RQ14 - Match/capture interrupt enabled by bit 1
// RQ15 - Software clears counter and pending together
// RQ16 - Software clears match pending by writing zero
// RQ17 - Counter, comparator and reference are 8 bits
// RQ18 - Count per tick; external clock synchronised
// RQ19 - Field encodings chosen and documented here
module tmra_timer
    import tmra_pkg::*;
#(
    parameter int CNT_W = 8,
    parameter int DIV_W = 10
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    output logic [7:0] reg_rdata,
    input wire logic external_clock_pin,
    input wire logic capture_input_pin,
    output logic match_pwm_output_pin,
    output logic capture_pin_out,
    output logic capture_pin_oe,
    output logic overflow_interrupt,
    output logic match_capture_interrupt,
    output logic [7:0] irq_vector,
    input wire logic ovf_serviced,
    input wire logic mc_serviced
);
    logic [7:0] timer_control_q, timer_control_d; // Control register
    logic [CNT_W-1:0] timer_counter_value_q, timer_counter_value_d; // Up-counter
    logic [CNT_W-1:0] reference_data_register_q, reference_data_register_d; // Reference
    logic [7:0] port0_control_high_q, port0_control_high_d; // Port 0 high control
    logic cap_out_q, cap_out_d; // Output latch for capture pin used as port
    logic out_q, out_d; // Match/PWM output level
    logic ov_pend_q, ov_pend_d; // Overflow pending
    logic mc_pend_q, mc_pend_d; // Match/capture pending
    logic cap_hist_q, cap_hist_d; // Previous capture pin level
    logic tick; // Timer clock enable pulse
    tmra_mode_t mode; // Decoded mode
    logic pwm_mode; // Either PWM encoding
    logic wr_ctrl; // Control register write
    logic wr_pend; // Pending register write
    logic match; // Comparator hit
    logic wrap; // Counter overflow event
    logic cap_edge; // Selected capture edge
    logic cap_en; // Pin configured for capture
    logic wr_data; // Reference register write
    logic wr_p0h; // Port 0 high control write
    logic wr_latch; // Port output latch write
    logic clr_cnt; // Software counter clear strobe
    logic clr_mc; // Match/capture flag clear, any source
    logic clr_ov; // Overflow flag clear, any source
    logic set_mc; // Hardware match/capture request
    logic set_ov; // Hardware overflow request

    // Write decode helper
    function automatic logic tmra_hit(input logic [7:0] a, input logic [7:0] b, input logic w);
        return w && (a == b);
    endfunction : tmra_hit

    // Prescaler and external clock synchroniser
    tmra_tick #(
        .DIV_W(DIV_W)
    ) u_tick (
        .clk(clk),
        .sys_rst(sys_rst),
        .clk_sel(timer_control_q[`TMRA_B_CLKS_HI:`TMRA_B_CLKS_LO]),
        .ext_clk_pin(external_clock_pin),
        .tick(tick)
    );

    // Control layout: [7:6] clock 0 /1024, 1 /256, 2 /64, 3 external pin
    // [5:4] mode 0 interval, 1 capture, 2 or 3 PWM
    // Bit 3 clears the counter, bit 0 clears the match flag; both read as zero
    // Bit 2 enables the overflow request, bit 1 the match/capture request
    // Pending register: bit 0 match/capture, bit 1 overflow; a written zero clears
    // Port 0 high: bit 1 selects output, else bit 0 picks the capture edge
    // Edge code: 0 rising, 1 falling
    // Decode of mode and events
    always_comb begin
        mode = tmra_mode_t'(timer_control_q[`TMRA_B_MODE_HI:`TMRA_B_MODE_LO]); // [RQ1] [RQ19]
        pwm_mode = (mode == TMRA_PWM) || (mode == TMRA_PWM_ALT);
        wr_ctrl = tmra_hit(reg_addr, `TMRA_CTRL_ADDR, reg_wr);
        wr_pend = tmra_hit(reg_addr, `TMRA_PEND_ADDR, reg_wr);
        match = tick && (timer_counter_value_q == reference_data_register_q); // [RQ17]
        wrap = tick && (timer_counter_value_q == {CNT_W{1'b1}});
        cap_en = !port0_control_high_q[`TMRA_B_P0_OUT]; // [RQ10]
        // Edge select: 0 rising, 1 falling
        if (port0_control_high_q[`TMRA_B_EDGE]) begin
            cap_edge = cap_en && cap_hist_q && !capture_input_pin; // [RQ9]
        end else begin
            cap_edge = cap_en && !cap_hist_q && capture_input_pin; // [RQ9]
        end
        // Write strobes of the other registers
        wr_data = tmra_hit(reg_addr, `TMRA_DATA_ADDR, reg_wr);
        wr_p0h = tmra_hit(reg_addr, `TMRA_P0H_ADDR, reg_wr);
        wr_latch = tmra_hit(reg_addr, `TMRA_CNT_ADDR, reg_wr);
        // Control bit 3 clears the counter when written one
        clr_cnt = wr_ctrl && reg_wdata[`TMRA_B_CLR]; // [RQ13] [RQ15]
        // Match flag clears: control bit 0, zero in pending register, service
        clr_mc = (wr_ctrl && reg_wdata[`TMRA_B_PCLR]) || // [RQ15]
            (wr_pend && !reg_wdata[`TMRA_PEND_MC]) || mc_serviced; // [RQ16]
        // Overflow flag clears: zero in pending register, service
        clr_ov = (wr_pend && !reg_wdata[`TMRA_PEND_OV]) || ovf_serviced; // [RQ4]
        // Overflow request only with its enable bit
        set_ov = wrap && timer_control_q[`TMRA_B_OVIE]; // [RQ3] [RQ11]
        // Match in interval or PWM, selected edge in capture mode
        set_mc = timer_control_q[`TMRA_B_MCIE] && (((mode == TMRA_INTERVAL) && match) || // [RQ14] [RQ5]
            (pwm_mode && match) || ((mode == TMRA_CAPTURE) && cap_edge)); // [RQ11]
    end

    // Control group: next values of the software registers
    always_comb begin
        // Hold unless a write below changes it
        timer_control_d = timer_control_q;
        port0_control_high_d = port0_control_high_q;
        cap_out_d = cap_out_q;
        // Strobe bits 3 and 0 act once and read back as zero
        if (wr_ctrl) begin
            timer_control_d = reg_wdata; // [RQ1] [RQ2]
            timer_control_d[`TMRA_B_CLR] = 1'b0;
            timer_control_d[`TMRA_B_PCLR] = 1'b0;
        end
        // Capture or output mode of the shared pin
        if (wr_p0h) begin
            port0_control_high_d = reg_wdata; // [RQ10]
        end
        // Only one bit reaches the pin in output mode
        if (wr_latch) begin
            cap_out_d = reg_wdata[`TMRA_B_LATCH];
        end
    end

    // Control group: register stage
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            timer_control_q <= `TMRA_CTRL_RST; // [RQ12]
            port0_control_high_q <= 8'h00;
            cap_out_q <= 1'b0;
        end else begin
            timer_control_q <= timer_control_d;
            port0_control_high_q <= port0_control_high_d;
            cap_out_q <= cap_out_d;
        end
    end

    // Counter group: tick count, interval restart, software clear
    always_comb begin
        // Hold between ticks
        timer_counter_value_d = timer_counter_value_q;
        // One step per timer clock, FFH wraps to 00H
        if (tick) begin
            timer_counter_value_d = timer_counter_value_q + CNT_W'(1); // [RQ18] [RQ6] [RQ8]
        end
        // Only interval mode restarts on a match
        if ((mode == TMRA_INTERVAL) && match) begin
            timer_counter_value_d = '0; // [RQ5]
        end
        // Software clear wins at any time
        if (clr_cnt) begin
            timer_counter_value_d = '0; // [RQ13]
        end
    end

    // Counter group: register stage
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            timer_counter_value_q <= '0;
        end else begin
            timer_counter_value_q <= timer_counter_value_d;
        end
    end

    // Reference group: capture load, software write wins
    always_comb begin
        // Hold unless captured or written
        reference_data_register_d = reference_data_register_q;
        // Selected edge copies the running count
        if ((mode == TMRA_CAPTURE) && cap_edge) begin
            reference_data_register_d = timer_counter_value_q; // [RQ9]
        end
        // Direct write of the reference value
        if (wr_data) begin
            reference_data_register_d = reg_wdata[CNT_W-1:0];
        end
    end

    // Reference group: register stage
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            reference_data_register_q <= '0;
        end else begin
            reference_data_register_q <= reference_data_register_d;
        end
    end

    // Output group: match toggle or PWM level, capture pin history
    always_comb begin
        // Hold the pin level by default
        out_d = out_q;
        cap_hist_d = capture_input_pin;
        unique case (mode)
            TMRA_INTERVAL: begin
                // Toggle on every match
                if (match) begin
                    out_d = !out_q; // [RQ5]
                end
            end
            TMRA_CAPTURE: begin
                // Output keeps its level while capturing
                out_d = out_q;
            end
            TMRA_PWM, TMRA_PWM_ALT: begin
                // High while the reference exceeds the count of the next edge
                out_d = (reference_data_register_d > timer_counter_value_d); // [RQ7]
            end
        endcase
    end

    // Output group: register stage
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            out_q <= 1'b0;
            cap_hist_q <= 1'b0;
        end else begin
            out_q <= out_d;
            cap_hist_q <= cap_hist_d;
        end
    end

    // Pending group: a hardware set wins over a clear in the same cycle
    always_comb begin
        // Flags stand until cleared
        ov_pend_d = ov_pend_q;
        mc_pend_d = mc_pend_q;
        // Clears from software writes and service pulses
        if (clr_ov) begin
            ov_pend_d = 1'b0; // [RQ4]
        end
        if (clr_mc) begin
            mc_pend_d = 1'b0; // [RQ16]
        end
        // Sets last so that they win
        if (set_ov) begin
            ov_pend_d = 1'b1; // [RQ3] [RQ11]
        end
        if (set_mc) begin
            mc_pend_d = 1'b1; // [RQ3] [RQ14]
        end
    end

    // Pending group: register stage
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ov_pend_q <= 1'b0;
            mc_pend_q <= 1'b0;
        end else begin
            ov_pend_q <= ov_pend_d;
            mc_pend_q <= mc_pend_d;
        end
    end

    // Read mux, unmapped reads give zero
    always_comb begin
        reg_rdata = 8'h00;
        unique case (reg_addr)
            `TMRA_CTRL_ADDR: reg_rdata = timer_control_q;
            `TMRA_PEND_ADDR: reg_rdata = {6'h00, ov_pend_q, mc_pend_q};
            `TMRA_DATA_ADDR: reg_rdata = 8'(reference_data_register_q);
            `TMRA_CNT_ADDR: reg_rdata = 8'(timer_counter_value_q);
            `TMRA_P0H_ADDR: reg_rdata = port0_control_high_q;
            default: reg_rdata = 8'h00;
        endcase
    end

    // Pin and interrupt outputs
    always_comb begin
        match_pwm_output_pin = out_q;
        capture_pin_oe = port0_control_high_q[`TMRA_B_P0_OUT]; // [RQ10]
        capture_pin_out = cap_out_q;
        overflow_interrupt = ov_pend_q; // [RQ3]
        match_capture_interrupt = mc_pend_q; // [RQ3]
        irq_vector = mc_pend_q ? `TMRA_VEC_MC : (ov_pend_q ? `TMRA_VEC_OV : 8'h00);
    end
endmodule : tmra_timer

/* File: sim/tmra_sva.sv */
// Port assertions for the 8-bit timer
module tmra_sva (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic [7:0] reg_rdata,
    input wire logic capture_pin_oe,
    input wire logic overflow_interrupt,
    input wire logic match_capture_interrupt,
    input wire logic [7:0] irq_vector,
    input wire logic ovf_serviced,
    input wire logic mc_serviced
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    // One write strobe to a given address
    sequence s_wr(a);
        reg_wr && reg_addr == a;
    endsequence
    a_rst_quiet: assert property ($past(sys_rst) |-> !overflow_interrupt && !match_capture_interrupt)
        else $error("Pending flags not cleared by reset");
    a_vec_match: assert property (match_capture_interrupt |-> irq_vector == 8'hc0)
        else $error("Match vector wrong");
    a_vec_ovf: assert property (overflow_interrupt && !match_capture_interrupt |-> irq_vector == 8'hc2)
        else $error("Overflow vector wrong");
    a_vec_idle: assert property (!overflow_interrupt && !match_capture_interrupt |-> irq_vector == 8'h00)
        else $error("Vector without request");
    a_mc_cleared: assert property ($fell(match_capture_interrupt) |-> $past(mc_serviced)
        || $past(reg_wr && reg_addr == 8'he2 && !reg_wdata[0]) || $past(reg_wr && reg_addr == 8'he1 && reg_wdata[0]))
        else $error("Match pending fell without cause");
    a_ovf_cleared: assert property ($fell(overflow_interrupt) |-> $past(ovf_serviced)
        || $past(reg_wr && reg_addr == 8'he2 && !reg_wdata[1])) else $error("Overflow pending fell without cause");
    a_oe_follow: assert property (s_wr(8'he6) |=> capture_pin_oe == $past(reg_wdata[1]))
        else $error("Port enable does not follow write");
    a_ctrl_read: assert property (s_wr(8'he1) ##1 reg_addr == 8'he1
        |-> reg_rdata == {$past(reg_wdata[7:4]), 1'b0, $past(reg_wdata[2:1]), 1'b0}) else $error("Control readback");
endmodule : tmra_sva
bind tmra_timer tmra_sva u_sva (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rdata(reg_rdata), .capture_pin_oe(capture_pin_oe), .overflow_interrupt(overflow_interrupt),
    .match_capture_interrupt(match_capture_interrupt), .irq_vector(irq_vector), .ovf_serviced(ovf_serviced),
    .mc_serviced(mc_serviced));

/* File: sim/tmra_pins.sv */
// Far-side model: external timer clock source and capture signal
module tmra_pins (
    input wire logic clk,
    output logic ext_clk,
    output logic cap_in
);
    timeunit 1ns;
    timeprecision 1ns;
    // Clock idles low outside bursts
    initial begin
        ext_clk = 1'b0;
        cap_in = 1'b0;
    end
    // Slow pulses, three system clocks high, four low between pulses
    task automatic pulses(input int n);
        repeat (n) begin
            @(negedge clk) ext_clk = 1'b1;
            repeat (3) @(negedge clk);
            ext_clk = 1'b0;
            repeat (3) @(negedge clk);
        end
    endtask : pulses
    // One level change on the capture line
    task automatic edge_to(input logic v);
        @(negedge clk) cap_in = v;
        repeat (4) @(negedge clk);
    endtask : edge_to
endmodule : tmra_pins

/* File: sim/eight_bit_timer_with_capture_pwm_tb_top.sv */
// Self-checking bench for the 8-bit timer
`include "tmra_cfg.svh"
module eight_bit_timer_with_capture_pwm_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, ovf_serviced = 1'b0, mc_serviced = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, irq_vector;
    logic ext_clk, cap_in, pin, pin_out, pin_oe, ovf, mc;
    int n_fail = 0, checked = 0, cnt = 0, ref_v = 0, div;
    bit tog, ovp;
    logic [31:0] seed = 32'h6e9b;
    always #50 clk = ~clk;
    tmra_timer DUT (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rdata(reg_rdata), .external_clock_pin(ext_clk), .capture_input_pin(cap_in),
        .match_pwm_output_pin(pin), .capture_pin_out(pin_out), .capture_pin_oe(pin_oe),
        .overflow_interrupt(ovf), .match_capture_interrupt(mc), .irq_vector(irq_vector),
        .ovf_serviced(ovf_serviced), .mc_serviced(mc_serviced));
    tmra_pins u_pins (.clk(clk), .ext_clk(ext_clk), .cap_in(cap_in));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk);
        reg_wr = 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
        @(negedge clk);
        reg_addr = a;
        #1 chk(what, exp, reg_rdata);
    endtask : rd
    // Model: md 0 interval, 1 capture, 2 PWM
    task automatic run(input int n, input int md);
        repeat (n) begin
            u_pins.pulses(1);
            if (md == 0 && cnt == ref_v) begin
                cnt = 0;
                tog = ~tog;
            end else begin
                ovp |= (cnt == 255);
                cnt = (cnt + 1) % 256;
            end
            rd(`TMRA_CNT_ADDR, cnt[7:0], "counter");
            if (md != 1) chk("out pin", {7'h00, (md == 2) ? (ref_v > cnt) : tog}, {7'h00, pin});
        end
    endtask : run
    task automatic conclude();
        $display("Comparisons %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : conclude
    initial begin
        repeat (100000) @(posedge clk);
        n_fail++;
        conclude();
    end
    initial begin
        repeat (2) @(posedge clk);
        @(negedge clk) sys_rst = 1'b0;
        rd(`TMRA_CTRL_ADDR, 8'h00, "control reset");
        rd(8'h7f, 8'h00, "unmapped");
        seed = lfsr(seed);
        ref_v = seed[2:0] + 1;
        wr(`TMRA_DATA_ADDR, ref_v[7:0]);
        wr(`TMRA_CTRL_ADDR, 8'hcb);
        run(2 * ref_v + 3, 0);
        chk("match pend", 8'h01, {7'h00, mc});
        @(negedge clk) mc_serviced = 1'b1;
        @(negedge clk) mc_serviced = 1'b0;
        chk("match serviced", 8'h00, {7'h00, mc});
        wr(`TMRA_CTRL_ADDR, 8'hca);
        cnt = 0;
        rd(`TMRA_CNT_ADDR, 8'h00, "cleared");
        run(ref_v + 1, 0);
        wr(`TMRA_PEND_ADDR, 8'h02);
        rd(`TMRA_PEND_ADDR, 8'h00, "sw clear");
        seed = lfsr(seed);
        ref_v = seed[7:0];
        wr(`TMRA_DATA_ADDR, ref_v[7:0]);
        wr(`TMRA_CTRL_ADDR, 8'hec);
        cnt = 0;
        run(260, 2);
        chk("overflow", {7'h00, ovp}, {7'h00, ovf});
        chk("pwm match pend disabled", 8'h00, {7'h00, mc});
        @(negedge clk) ovf_serviced = 1'b1;
        @(negedge clk) ovf_serviced = 1'b0;
        chk("ovf serviced", 8'h00, {7'h00, ovf});
        wr(`TMRA_P0H_ADDR, 8'h00);
        wr(`TMRA_CTRL_ADDR, 8'hda);
        cnt = 0;
        run(seed[11:8] + 1, 1);
        u_pins.edge_to(1'b1);
        rd(`TMRA_DATA_ADDR, cnt[7:0], "capture rise");
        chk("capture pend", 8'h01, {7'h00, mc});
        wr(`TMRA_P0H_ADDR, 8'h01);
        run(3, 1);
        u_pins.edge_to(1'b0);
        rd(`TMRA_DATA_ADDR, cnt[7:0], "capture fall");
        wr(`TMRA_P0H_ADDR, 8'h02);
        wr(`TMRA_CNT_ADDR, 8'h01);
        chk("port out", 8'h03, {6'h00, pin_oe, pin_out});
        wr(`TMRA_DATA_ADDR, 8'hff);
        for (int k = 0; k < 3; k++) begin
            div = 1024 >> (2 * k);
            wr(`TMRA_CTRL_ADDR, {k[1:0], 6'h08});
            reg_addr = `TMRA_CNT_ADDR;
            repeat (div * 5 / 2) @(negedge clk);
            // Free prescaler phase: two and a half periods hold two or three ticks
            #1 chk("prescaled", 8'h02, (reg_rdata >= 8'h02 && reg_rdata <= 8'h03) ? 8'h02 : reg_rdata);
        end
        conclude();
    end
endmodule : eight_bit_timer_with_capture_pwm_tb_top
